// [redriver_smbus_register_bank.sv]
`timescale 1ns/1ps
`include "redriver_defines.svh"

// Behaviour
// - Eight channels form two banks of four, each answering its own target address.
// - Address straps are sampled once, shortly after power-on reset releases.
// - Bank address is 0x18 plus twice the strap pair code; second bank adds one.
// - Channel windows are consecutive 32-byte ranges, lowest channel at offset zero.
// - Whole-bank broadcast range writes all four channels, reads the lowest.
// - First pair range writes channels one and two, reads the first.
// - Second pair range writes channels three and four, reads the third.
// - Shared registers sit in the top range and are always accessible.
// - Channels have identical registers; a write to one leaves others untouched.
// - Read-only fields ignore writes; self-clearing bits act once and read zero.
// - Soft reset bit 6 of the general register restores all defaults.
// - Bit 0 of the general register forces a configuration load.
// - Load status: complete bit 7, failed bit 6, attempt count bits 5:4.
// - After power up the configuration is fetched with no host involvement.
// - Identity codes: three bits at 3:1 of one register, eight in the next.
// - Receiver termination per polarity latches in status bits 7 and 6.
// - Equalizer register: bypass bit 7, first boost 6:3, second boost 2:0.
// - Mute register bit 3 silences the output; other bits read zero.
// - Gain register resets to 0x05; reserved fields read zero.
// - Gain register: midband profile 6:3, flat gain select 2:0.
module redriver_smbus_register_bank import redriver_pkg::*; #(
   parameter logic [2:0] ID_LOW_CODE = 3'h5, // This value is arbitrary.
   parameter logic [7:0] ID_HIGH_CODE = 8'hA5 // This value is arbitrary.
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [2:0] strap_addr_high,
   input wire logic [2:0] strap_addr_low,
   input wire logic eeprom_autoload_en,
   input wire logic [7:0] rx_term_p,
   input wire logic [7:0] rx_term_n,
   output logic ee_req,
   output logic [4:0] ee_index,
   input wire logic ee_valid,
   input wire logic [7:0] ee_data,
   input wire logic ee_error,
   output logic [6:0] bank0_addr,
   output logic addr_valid,
   output ch_cfg_t [7:0] ch_cfg
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [24:0] async_in;
   logic [24:0] sync1_q;
   logic [24:0] sync2_q;
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_s, sda_s, autoload_s;
   logic [2:0] strap_hi_s, strap_lo_s;
   logic [7:0] rxp_s, rxn_s;

   assign async_in = {scl_in, sda_in, strap_addr_high, strap_addr_low, eeprom_autoload_en, rx_term_p, rx_term_n};
   assign scl_s = sync2_q[24];
   assign sda_s = sync2_q[23];
   assign strap_hi_s = sync2_q[22:20];
   assign strap_lo_s = sync2_q[19:17];
   assign autoload_s = sync2_q[16];
   assign rxp_s = sync2_q[15:8];
   assign rxn_s = sync2_q[7:0];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 25'h1800000;
         sync2_q <= 25'h1800000;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   // The synchronisers hold reset values for two cycles, so the capture waits for them to fill.
   logic [1:0] cap_cnt_q;
   logic cap_now;
   logic [6:0] bank0_addr_q;
   logic addr_valid_q;

   assign cap_now = (cap_cnt_q == `STRAP_SETTLE);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cap_cnt_q <= 2'h0;
         bank0_addr_q <= 7'h00;
         addr_valid_q <= 1'b0;
      end else if (cap_cnt_q != 2'h3) begin
         cap_cnt_q <= cap_cnt_q + 2'h1;
         if (cap_now) begin
            bank0_addr_q <= `BANK_BASE_ADDR + {2'b00, strap_hi_s[1:0], strap_lo_s[1:0], 1'b0};
            addr_valid_q <= (strap_hi_s < `STRAP_FLOAT) && (strap_lo_s < `STRAP_FLOAT);
         end
      end
   end

   assign bank0_addr = bank0_addr_q;
   assign addr_valid = addr_valid_q;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic [3:0] win_mask(input logic [2:0] region);
      unique case (region)
         `REGION_ALL: win_mask = 4'hF;
         `REGION_PAIR_LO: win_mask = 4'h3;
         `REGION_PAIR_HI: win_mask = 4'hC;
         `REGION_SHARED: win_mask = 4'h0;
         default: win_mask = 4'(4'h1 << region[1:0]);
      endcase
   endfunction

   function automatic logic [1:0] win_read(input logic [2:0] region);
      win_read = region[2] ? {region[1] & ~region[0], 1'b0} : region[1:0];
   endfunction

   smb_state_t st_q;
   logic [3:0] bit_q;
   logic ack_q;
   logic mack_q;
   logic [7:0] shift_q;
   logic [7:0] tx_q;
   logic [7:0] ptr_q;
   logic bank_q;
   logic sda_oe_q;
   logic start_det, stop_det, scl_rise, scl_fall, byte_end;
   logic addr_hit, host_wr, gen_wr, soft_rst, force_load, ack_now;
   logic [2:0] region;
   logic [7:0] wr_mask, chan_wr;

   assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   assign scl_rise = scl_s & ~scl_prev_q;
   assign scl_fall = ~scl_s & scl_prev_q;
   assign byte_end = scl_fall & ~ack_q & (bit_q == 4'h8);
   assign addr_hit = addr_valid_q & (shift_q[7:2] == bank0_addr_q[6:1]);
   assign region = ptr_q[7:5];
   assign wr_mask = bank_q ? {win_mask(region), 4'h0} : {4'h0, win_mask(region)};
   assign host_wr = byte_end & (st_q == S_WDATA);
   assign chan_wr = wr_mask & {8{host_wr}};
   assign gen_wr = host_wr & (ptr_q == `OFS_GENERAL);
   assign soft_rst = gen_wr & shift_q[`GEN_SOFT_RESET_BIT];
   assign force_load = gen_wr & shift_q[`GEN_FORCE_LOAD_BIT];
   assign ack_now = (st_q == S_ADDR) ? addr_hit : (st_q != S_RDATA);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [7:0] eq_q [8];
   logic mute_q [8];
   logic [6:0] gain_q [8];
   logic [1:0] rxdet_q [8];
   load_state_t ld_q;
   logic [2:0] ld_ch_q;
   logic [1:0] ld_k_q;
   ee_status_t ee_st_q;
   logic ee_wr_any;

   assign ee_wr_any = ee_valid & ~ee_error & (ld_q == L_FETCH);

   for (genvar c = 0; c < 8; c++) begin : g_ch
      logic ew;
      assign ew = ee_wr_any & (ld_ch_q == 3'(c));

      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            eq_q[c] <= `EQ_RESET;
            mute_q[c] <= 1'b0;
            gain_q[c] <= `GAIN_RESET;
         end else if (soft_rst) begin
            eq_q[c] <= `EQ_RESET;
            mute_q[c] <= 1'b0;
            gain_q[c] <= `GAIN_RESET;
         end else if (ew) begin
            if (ld_k_q == 2'h0) eq_q[c] <= ee_data;
            if (ld_k_q == 2'h1) mute_q[c] <= ee_data[`MUTE_BIT];
            if (ld_k_q == 2'h2) gain_q[c] <= ee_data[6:0];
         end else if (chan_wr[c]) begin
            if (ptr_q[4:0] == `OFS_EQUALIZER) eq_q[c] <= shift_q;
            if (ptr_q[4:0] == `OFS_MUTE) mute_q[c] <= shift_q[`MUTE_BIT];
            if (ptr_q[4:0] == `OFS_GAIN) gain_q[c] <= shift_q[6:0];
         end
      end

      // A detection arriving with a soft reset is kept: the set wins.
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            rxdet_q[c] <= 2'b00;
         end else begin
            rxdet_q[c] <= (soft_rst ? 2'b00 : rxdet_q[c]) | {rxp_s[c], rxn_s[c]};
         end
      end

      assign ch_cfg[c] = {eq_q[c], mute_q[c], gain_q[c]};
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [2:0] rd_ch;
   logic [7:0] ch_byte, sh_byte, rd_byte;

   assign rd_ch = {bank_q, win_read(region)};
   assign ch_byte = (ptr_q[4:0] == `OFS_RX_DETECT) ? {rxdet_q[rd_ch], 6'h00} :
                    (ptr_q[4:0] == `OFS_EQUALIZER) ? eq_q[rd_ch] :
                    (ptr_q[4:0] == `OFS_MUTE) ? {4'h0, mute_q[rd_ch], 3'h0} :
                    (ptr_q[4:0] == `OFS_GAIN) ? {1'b0, gain_q[rd_ch]} : 8'h00;
   // Identity low bit 0 is undefined, so it is simply driven low.
   assign sh_byte = (ptr_q == `OFS_EE_STATUS) ? {ee_st_q, 4'h0} :
                    (ptr_q == `OFS_ID_LOW) ? {4'h0, ID_LOW_CODE, 1'b0} :
                    (ptr_q == `OFS_ID_HIGH) ? ID_HIGH_CODE : 8'h00;
   assign rd_byte = (region == `REGION_SHARED) ? sh_byte : ch_byte;

   // ----------------------------------------------------------------
   // Management bus target
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= S_IDLE;
         bit_q <= 4'h0;
         ack_q <= 1'b0;
         mack_q <= 1'b0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         bank_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (start_det) begin
         st_q <= S_ADDR;
         bit_q <= 4'h0;
         ack_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (stop_det) begin
         st_q <= S_IDLE;
         sda_oe_q <= 1'b0;
      end else if (st_q != S_IDLE) begin
         if (scl_rise && ack_q) begin
            mack_q <= ~sda_s;
         end else if (scl_rise && bit_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
         end else if (byte_end) begin
            ack_q <= 1'b1;
            sda_oe_q <= ack_now;
            if (st_q == S_ADDR && addr_hit) bank_q <= shift_q[1];
            if (st_q == S_OFFS) ptr_q <= shift_q;
            if (st_q == S_RDATA) ptr_q <= ptr_q + 8'h01;
         end else if (scl_fall && !ack_q && st_q == S_RDATA) begin
            tx_q <= {tx_q[6:0], 1'b0};
            sda_oe_q <= ~tx_q[6];
         end else if (scl_fall && ack_q) begin
            ack_q <= 1'b0;
            bit_q <= 4'h0;
            sda_oe_q <= 1'b0;
            unique case (st_q)
               S_ADDR: begin
                  if (!addr_hit) begin
                     st_q <= S_IDLE;
                  end else if (shift_q[0]) begin
                     st_q <= S_RDATA;
                     tx_q <= rd_byte;
                     sda_oe_q <= ~rd_byte[7];
                  end else begin
                     st_q <= S_OFFS;
                  end
               end
               S_OFFS: st_q <= S_WDATA;
               S_WDATA: ptr_q <= ptr_q + 8'h01;
               S_RDATA: begin
                  if (mack_q) begin
                     tx_q <= rd_byte;
                     sda_oe_q <= ~rd_byte[7];
                  end else begin
                     st_q <= S_IDLE;
                  end
               end
               S_IDLE: st_q <= S_IDLE;
            endcase
         end
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_q;

   // ----------------------------------------------------------------
   // Configuration load engine
   // ----------------------------------------------------------------
   // A forced load while a fetch runs is ignored rather than restarting it.
   logic start_load;

   assign start_load = force_load | (cap_now & autoload_s);
   assign ee_req = (ld_q == L_FETCH);
   assign ee_index = {ld_ch_q, ld_k_q};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ld_q <= L_IDLE;
         ld_ch_q <= 3'h0;
         ld_k_q <= 2'h0;
         ee_st_q <= '0;
      end else if (soft_rst) begin
         ld_q <= L_IDLE;
         ee_st_q <= '0;
      end else begin
         unique case (ld_q)
            L_IDLE: begin
               if (start_load) begin
                  ld_q <= L_FETCH;
                  ld_ch_q <= 3'h0;
                  ld_k_q <= 2'h0;
                  ee_st_q.complete <= 1'b0;
                  ee_st_q.failed <= 1'b0;
                  if (ee_st_q.attempts != `EE_ATTEMPT_MAX) ee_st_q.attempts <= ee_st_q.attempts + 2'h1;
               end
            end
            L_FETCH: begin
               if (ee_error) begin
                  ld_ch_q <= 3'h0;
                  ld_k_q <= 2'h0;
                  if (ee_st_q.attempts == `EE_ATTEMPT_MAX) begin
                     ld_q <= L_IDLE;
                     ee_st_q.failed <= 1'b1;
                  end else begin
                     ee_st_q.attempts <= ee_st_q.attempts + 2'h1;
                  end
               end else if (ee_valid) begin
                  if (ld_k_q == `EE_LAST_FIELD) begin
                     ld_k_q <= 2'h0;
                     ld_ch_q <= ld_ch_q + 3'h1;
                     if (ld_ch_q == `EE_LAST_CH) begin
                        ld_q <= L_IDLE;
                        ee_st_q.complete <= 1'b1;
                     end
                  end else begin
                     ld_k_q <= ld_k_q + 2'h1;
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_strap_hold;
      @(posedge clk) disable iff (!nrst) (cap_cnt_q == 2'h3) |=> $stable(bank0_addr_q) && $stable(addr_valid_q);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap address changed after capture");

   property p_addr_formula;
      @(posedge clk) disable iff (!nrst)
         cap_now |=> bank0_addr_q == 7'(7'h18 + 7'($past(strap_hi_s[1:0]) * 8) + 7'($past(strap_lo_s[1:0]) * 2));
   endproperty
   a_addr_formula: assert property (p_addr_formula) else $error("bank address not base plus twice code");

   property p_float_invalid;
      @(posedge clk) disable iff (!nrst) cap_now && (strap_hi_s == 3'h4 || strap_lo_s == 3'h4) |=> !addr_valid_q;
   endproperty
   a_float_invalid: assert property (p_float_invalid) else $error("floating strap gave a valid address");

   property p_bank_isolated;
      @(posedge clk) disable iff (!nrst) host_wr |-> (bank_q ? wr_mask[3:0] == 4'h0 : wr_mask[7:4] == 4'h0);
   endproperty
   a_bank_isolated: assert property (p_bank_isolated) else $error("write reached the other bank");

   property p_broadcast_all;
      @(posedge clk) disable iff (!nrst) host_wr && region == 3'h4 && ptr_q[4:0] == 5'h01
         |=> eq_q[{bank_q, 2'h0}] == eq_q[{bank_q, 2'h3}] || $past(ee_wr_any);
   endproperty
   a_broadcast_all: assert property (p_broadcast_all) else $error("bank broadcast missed a channel");

   property p_pair_masks;
      @(posedge clk) disable iff (!nrst) host_wr && region[2] && region != 3'h7
         |-> (region == 3'h5 ? (wr_mask[3:0] | wr_mask[7:4]) == 4'h3 :
              region == 3'h6 ? (wr_mask[3:0] | wr_mask[7:4]) == 4'hC : (wr_mask[3:0] | wr_mask[7:4]) == 4'hF);
   endproperty
   a_pair_masks: assert property (p_pair_masks) else $error("pair broadcast mask wrong");

   property p_shared_no_channel;
      @(posedge clk) disable iff (!nrst) host_wr && region == 3'h7 |-> chan_wr == 8'h00;
   endproperty
   a_shared_no_channel: assert property (p_shared_no_channel) else $error("shared write touched a channel");

   property p_single_channel;
      @(posedge clk) disable iff (!nrst) host_wr && region == 3'h0 && !bank_q && !ee_wr_any && !soft_rst
         |=> $stable(eq_q[1]) && $stable(gain_q[2]);
   endproperty
   a_single_channel: assert property (p_single_channel) else $error("channel write leaked sideways");

   property p_soft_reset;
      @(posedge clk) disable iff (!nrst) soft_rst |=> eq_q[5] == 8'h00 && gain_q[5] == 7'h05 && ld_q == L_IDLE;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not restore defaults");

   property p_force_load;
      @(posedge clk) disable iff (!nrst) force_load && !soft_rst && ld_q == L_IDLE |=> ee_req && ee_index == 5'h00;
   endproperty
   a_force_load: assert property (p_force_load) else $error("forced load did not start");

   property p_fail_count;
      @(posedge clk) disable iff (!nrst) $rose(ee_st_q.failed) |-> ee_st_q.attempts == 2'h3 && !ee_req;
   endproperty
   a_fail_count: assert property (p_fail_count) else $error("failure flagged before the last attempt");

   property p_rx_latch;
      @(posedge clk) disable iff (!nrst) rxdet_q[0][1] && !soft_rst |=> rxdet_q[0][1];
   endproperty
   a_rx_latch: assert property (p_rx_latch) else $error("receiver detect flag dropped");

   property p_selfclear_read;
      @(posedge clk) disable iff (!nrst) ptr_q == 8'hE2 |-> rd_byte == 8'h00;
   endproperty
   a_selfclear_read: assert property (p_selfclear_read) else $error("self-clearing bits read back set");

   property p_addr_ack;
      @(posedge clk) disable iff (!nrst) byte_end && st_q == S_ADDR && addr_hit |=> sda_oe ##1 sda_oe;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("matching address not acknowledged");

   c_read_byte: cover property (@(posedge clk) disable iff (!nrst) st_q == S_RDATA && scl_fall && ack_q && mack_q);
   c_bank_write: cover property (@(posedge clk) disable iff (!nrst) host_wr && region == 3'h4);
   c_load_done: cover property (@(posedge clk) disable iff (!nrst) $rose(ee_st_q.complete));
   c_load_fail: cover property (@(posedge clk) disable iff (!nrst) $rose(ee_st_q.failed));

endmodule

// [redriver_defines.svh]
`ifndef REDRIVER_DEFINES_SVH
`define REDRIVER_DEFINES_SVH

// ----------------------------------------------------------------
// Target addressing
// ----------------------------------------------------------------
`define BANK_BASE_ADDR 7'h18
`define STRAP_FLOAT 3'h4
`define STRAP_SETTLE 2'h2

// ----------------------------------------------------------------
// Page layout and register offsets
// ----------------------------------------------------------------
`define OFS_RX_DETECT 5'h00
`define OFS_EQUALIZER 5'h01
`define OFS_MUTE 5'h02
`define OFS_GAIN 5'h03
`define OFS_GENERAL 8'hE2
`define OFS_EE_STATUS 8'hE3
`define OFS_ID_LOW 8'hF0
`define OFS_ID_HIGH 8'hF1
`define REGION_ALL 3'h4
`define REGION_PAIR_LO 3'h5
`define REGION_PAIR_HI 3'h6
`define REGION_SHARED 3'h7

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define GEN_SOFT_RESET_BIT 6
`define GEN_FORCE_LOAD_BIT 0
`define MUTE_BIT 3
`define EQ_RESET 8'h00
`define GAIN_RESET 7'h05

// ----------------------------------------------------------------
// Configuration load
// ----------------------------------------------------------------
`define EE_LAST_CH 3'h7
`define EE_LAST_FIELD 2'h2
`define EE_ATTEMPT_MAX 2'h3

`endif

// [redriver_pkg.sv]
package redriver_pkg;

   typedef struct packed {
      logic first_boost_bypass;
      logic [3:0] first_boost_level;
      logic [2:0] second_boost_level;
      logic output_silence;
      logic [3:0] midband_boost_profile;
      logic [2:0] flat_gain_select;
   } ch_cfg_t;

   typedef struct packed {
      logic complete;
      logic failed;
      logic [1:0] attempts;
   } ee_status_t;

   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_OFFS, S_WDATA, S_RDATA} smb_state_t;

   typedef enum logic {L_IDLE, L_FETCH} load_state_t;

endpackage

// [redriver_eeprom_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Configuration store model
// ------------------------------------------------------------
// Bytes are {index, 3'h3}, so any byte that lands in the wrong place shows up.
// Indices with bit 2 clear answer slowly and those with bit 2 set answer at once, so both pacings occur.
module redriver_eeprom_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ee_req,
   input wire logic [4:0] ee_index,
   input wire logic fail,
   output logic ee_valid,
   output logic ee_error,
   output logic [7:0] ee_data
);
   logic [1:0] gap_q;
   wire logic go = ee_req && (gap_q == 2'h3 || ee_index[2]) && !ee_valid && !ee_error;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gap_q <= 2'h0;
         ee_valid <= 1'b0;
         ee_error <= 1'b0;
         ee_data <= 8'hFF;
      end else begin
         gap_q <= gap_q + 2'h1;
         ee_valid <= go && !fail;
         ee_error <= go && fail;
         // Between bytes the data lines toggle, so a stale byte is never read twice.
         ee_data <= go ? {ee_index, 3'h3} : ~ee_data;
      end
   end
endmodule

// [redriver_smbus_register_bank_tb.sv]
`timescale 1ns/1ps
module redriver_smbus_register_bank_tb import redriver_pkg::*;;
   // ------------------------------------------------------------
   // Bench signals
   // ------------------------------------------------------------
   logic clk = 1'b0, nrst = 1'b0, scl = 1'b1, m_low = 1'b0, fail = 1'b0, autoload = 1'b1;
   logic [2:0] strap_hi = 3'h1, strap_lo = 3'h2;
   logic [7:0] rx_p = 8'h00, rx_n = 8'h00, r;
   logic ee_req, ee_valid, ee_error, sda_out, sda_oe, addr_valid, k;
   logic [4:0] ee_index;
   logic [7:0] ee_data;
   logic [6:0] bank0_addr;
   ch_cfg_t [7:0] ch_cfg;
   int err_total = 0, check_count = 0;
   logic [39:0] tbl [13];
   // The data line has a pull-up and is low while either side pulls it.
   wire logic sda = ~(m_low | sda_oe);
   always #2 clk = ~clk;
   redriver_smbus_register_bank #(.ID_LOW_CODE(3'h5), .ID_HIGH_CODE(8'hA5)) redriver_smbus_register_bank_inst (
      .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .strap_addr_high(strap_hi), .strap_addr_low(strap_lo), .eeprom_autoload_en(autoload),
      .rx_term_p(rx_p), .rx_term_n(rx_n), .ee_req(ee_req), .ee_index(ee_index), .ee_valid(ee_valid),
      .ee_data(ee_data), .ee_error(ee_error), .bank0_addr(bank0_addr), .addr_valid(addr_valid), .ch_cfg(ch_cfg));
   redriver_eeprom_model redriver_eeprom_model_inst (.clk(clk), .nrst(nrst), .ee_req(ee_req),
      .ee_index(ee_index), .fail(fail), .ee_valid(ee_valid), .ee_error(ee_error), .ee_data(ee_data));
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Bus phases of eight cycles leave margin over the four-cycle minimum and sync delay.
   task automatic bit_io(input logic b, output logic q);
      m_low = ~b;
      tick(8);
      scl = 1'b1;
      tick(4);
      q = sda;
      tick(4);
      scl = 1'b0;
      tick(4);
   endtask
   task automatic start();
      m_low = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(8);
      m_low = 1'b1;
      tick(8);
      scl = 1'b0;
      tick(4);
   endtask
   task automatic stop();
      m_low = 1'b1;
      tick(8);
      scl = 1'b1;
      tick(8);
      m_low = 1'b0;
      tick(8);
   endtask
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(a, ack);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d);
      logic [7:0] q;
      start();
      xfer({a, 1'b0}, 1'b1, q, k);
      chk({7'h0, k}, 8'h00);
      xfer(o, 1'b1, q, k);
      xfer(d, 1'b1, q, k);
      chk({7'h0, k}, 8'h00);
      stop();
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] o, output logic [7:0] v);
      logic [7:0] q;
      start();
      xfer({a, 1'b0}, 1'b1, q, k);
      xfer(o, 1'b1, q, k);
      start();
      xfer({a, 1'b1}, 1'b1, q, k);
      xfer(8'hFF, 1'b1, v, k);
      stop();
   endtask
   task automatic wait_load();
      int n;
      tick(6);
      for (n = 0; n < 4000 && ee_req !== 1'b0; n++) tick(1);
      if (n == 4000) begin
         err_total++;
         end_sim();
      end
   endtask
   initial begin
      tbl = '{40'h2421980100, 40'h2441332198, 40'h25815B615B, 40'h24A1112111, 40'h24C122C122,
         40'h24A1118111, 40'h2402FF0208, 40'h2403FF037F, 40'h2400FF0000, 40'h24F0FFF00A,
         40'h24F100F1A5, 40'h2405FF0500, 40'h25E5FFE500};
      tick(6);
      nrst = 1'b1;
      wait_load();
      chk({1'b0, bank0_addr}, 8'h24);
      chk({7'h0, addr_valid}, 8'h01);
      chk({7'h0, sda_out}, 8'h00);
      rd(7'h24, 8'h01, r);
      chk(r, 8'h03);
      rd(7'h24, 8'h03, r);
      chk(r, 8'h13);
      rd(7'h25, 8'h01, r);
      chk(r, 8'h83);
      rd(7'h24, 8'hE3, r);
      chk(r & 8'h80, 8'h80);
      wr(7'h24, 8'hE2, 8'h40);
      rd(7'h24, 8'h03, r);
      chk(r, 8'h05);
      rd(7'h24, 8'hE3, r);
      chk(r, 8'h00);
      foreach (tbl[i]) begin
         wr(tbl[i][38:32], tbl[i][31:24], tbl[i][23:16]);
         rd(tbl[i][38:32], tbl[i][15:8], r);
         chk(r, tbl[i][7:0]);
      end
      chk(ch_cfg[7][15:8], 8'h5B);
      chk(ch_cfg[1][15:8], 8'h11);
      chk(ch_cfg[3][15:8], 8'h22);
      chk({4'h0, ch_cfg[0].output_silence, ch_cfg[0].flat_gain_select}, 8'h0F);
      rx_p = 8'h01;
      rx_n = 8'h80;
      tick(8);
      rx_p = 8'h00;
      rx_n = 8'h00;
      rd(7'h24, 8'h00, r);
      chk(r, 8'h80);
      rd(7'h25, 8'h60, r);
      chk(r, 8'h40);
      start();
      xfer({7'h26, 1'b0}, 1'b1, r, k);
      stop();
      chk({7'h0, k}, 8'h01);
      // Every attempt fails, so the count must saturate and the failure flag rise.
      fail = 1'b1;
      wr(7'h25, 8'hE2, 8'h01);
      wait_load();
      rd(7'h25, 8'hE3, r);
      chk(r, 8'h70);
      rd(7'h25, 8'hE2, r);
      chk(r, 8'h00);
      // A floating strap with autoload off must give no valid address and no fetch.
      strap_lo = 3'h4;
      autoload = 1'b0;
      fail = 1'b0;
      nrst = 1'b0;
      tick(2);
      nrst = 1'b1;
      tick(6);
      chk({7'h0, addr_valid}, 8'h00);
      chk({7'h0, ee_req}, 8'h00);
      chk(ch_cfg[0][15:8], 8'h00);
      chk({1'b0, ch_cfg[0][6:0]}, 8'h05);
      start();
      xfer({7'h24, 1'b0}, 1'b1, r, k);
      stop();
      chk({7'h0, k}, 8'h01);
      end_sim();
   end
endmodule
